/* File: adc_seq_pkg.sv */
// Shared constants and types for the pipelined converter sequencer.
// Assumes one peripheral clock domain; the analog core is outside.
package adc_seq_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int RES_W = 12;
    localparam int WORD_W = 16;
    localparam int PRESC_W = 3;
    localparam int LAT_W = 4;
    localparam int MAX_INFLIGHT = 8;

    // ------------------------------------------------------------------
    // Resolution codes
    // ------------------------------------------------------------------
    localparam logic [1:0] RES_12R = 2'h0;
    localparam logic [1:0] RES_RSVD = 2'h1;
    localparam logic [1:0] RES_8R = 2'h2;
    localparam logic [1:0] RES_12L = 2'h3;

    // Latency pieces, in conversion clock cycles
    localparam logic [LAT_W-1:0] LAT_BASE = 4'h1;
    localparam logic [LAT_W-1:0] LAT_HALF8 = 4'h4;
    localparam logic [LAT_W-1:0] LAT_HALF12 = 4'h6;
    localparam logic [LAT_W-1:0] LAT_GAIN = 4'h1;

    // ------------------------------------------------------------------
    // Per-channel interrupt and event condition
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        COND_COMPLETE,
        COND_ABOVE,
        COND_BELOW
    } cond_t;

    typedef struct packed {
        logic gainUse;
        cond_t cond;
    } chan_cfg_t;

    // One pipeline slot
    typedef struct packed {
        logic busy;
        logic [1:0] chan;
        logic [LAT_W-1:0] left;
    } slot_t;

    // All-zero 16-bit word, the starting value of a formatted result
    localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

endpackage : adc_seq_pkg

/* File: pipelined_adc_sequencer.sv */
// Digital control of a four-channel pipelined converter.
// Assumes start bits and events are synchronous to clk, and the analog
// core returns its raw code at the end of each conversion.
//
// Notes on behaviour
// - One 12-bit threshold is shared by all four channels.
// - In compare mode a flag fires only when result is above or below threshold.
// - Software start bits or a selected event start one or several channels.
// - Conversion clock is the peripheral clock divided by a programmable prescaler.
// - A new sample can enter the pipeline on every conversion clock cycle.
// - Latency is one plus half resolution, plus one with gain stage.
// - Input is sampled in the first half of the conversion's first cycle.
// - MSB first, then 3 or 5 more cycles of two bits each.
// - Final cycle assembles result, then sets the channel completion flag.
// - Gain stage adds one cycle between start and converter sampling.
// - Second started channel samples the cycle after the first's sample and MSB.
// - A gain-stage channel delays the next channel's sample by one cycle.
// - Free-running mode re-arms all selected channels once the last channel of a sweep issues.
// - Up to 8 conversions may be in flight, finishing on successive cycles.
// - Each new completed result can raise a DMA request.
// - Each channel has its own interrupt and event settings.
// - Among pending starts the lowest-numbered channel is served first.
// - Flush aborts all conversions and restarts the conversion clock at once.
// - Flush comes from a software write or from the trigger event.
// - A software start bit clears once its conversion has begun.
// - After flush, pending starts and interrupted sweeps re-enter and complete.
// - Resolution 00 12-bit right, 10 8-bit right, 11 12-bit left, 01 reserved.
// - Signed 12-bit right mode copies the sign bit into bits 15 to 12.
`timescale 1ns/10ps

module pipelined_adc_sequencer
    import adc_seq_pkg::*;
#(
    parameter int SLOTS = MAX_INFLIGHT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [NUM_CH-1:0] channelStartWrite,
    input wire logic [NUM_CH-1:0] eventIn,
    input wire logic eventFlushEnable,
    input wire logic flushWrite,
    input wire logic [PRESC_W-1:0] prescaler,
    input wire logic [1:0] resolution,
    input wire logic signedSelect,
    input wire logic continuousSweepEnable,
    input wire logic [1:0] sweepSelect,
    input wire logic [RES_W-1:0] threshold,
    input wire chan_cfg_t [NUM_CH-1:0] chanCfg,
    input wire logic [WORD_W-1:0] calibIn,
    input wire logic calibWrite,
    input wire logic [RES_W-1:0] coreResult,
    input wire logic [NUM_CH-1:0] flagClear,
    output logic [NUM_CH-1:0] channelStartBits,
    output logic adcClkEnable,
    output logic sampleStrobe,
    output logic gainSampleStrobe,
    output logic [1:0] sampleChannel,
    output logic [WORD_W-1:0] calibValue,
    output logic [NUM_CH-1:0][WORD_W-1:0] chanResult,
    output logic [NUM_CH-1:0] chanFlag,
    output logic [NUM_CH-1:0] chanEvent,
    output logic [NUM_CH-1:0] dmaRequest
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [LAT_W-1:0] latency(input logic [1:0] res, input logic gain);
        logic [LAT_W-1:0] half;
        half = (res == RES_8R) ? LAT_HALF8 : LAT_HALF12;
        return LAT_BASE + half + (gain ? LAT_GAIN : '0);
    endfunction : latency

    function automatic logic [1:0] lowestSet(input logic [NUM_CH-1:0] v);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction : lowestSet

    function automatic logic [WORD_W-1:0] format(input logic [RES_W-1:0] raw,
                                                  input logic [1:0] res,
                                                  input logic sgn);
        logic [WORD_W-1:0] w;
        w = ZERO_WORD;
        case (res)
            RES_8R: w = {{8{sgn & raw[11]}}, raw[11:4]};
            RES_12L: w = {raw, 4'h0};
            default: w = {{4{sgn & raw[11]}}, raw};
        endcase
        return w;
    endfunction : format

    // ------------------------------------------------------------------
    // Conversion clock prescaler
    // ------------------------------------------------------------------
    logic [PRESC_W-1:0] divCnt_q;
    logic [NUM_CH-1:0] pending_q;
    logic [NUM_CH-1:0] startBits_q;
    logic [1:0] gainHold_q;
    slot_t [SLOTS-1:0] slot_q;
    logic [1:0] lastChan_q;

    wire logic flushNow = flushWrite | (eventFlushEnable & |eventIn);
    wire logic tick = enable & (divCnt_q == prescaler) & ~flushNow;
    wire logic flushTick = enable & flushNow;
    wire logic [NUM_CH-1:0] sweepMask = NUM_CH'((5'h2 << sweepSelect) - 5'h1);
    wire logic [NUM_CH-1:0] evStart = |eventIn ? (eventIn | sweepMask) & sweepMask : '0;
    wire logic [NUM_CH-1:0] reqAll = pending_q | startBits_q;
    wire logic haveReq = |reqAll;
    wire logic [1:0] pickChan = lowestSet(reqAll);
    wire logic pickGain = chanCfg[pickChan].gainUse;
    wire logic issueOk = (tick | flushTick) & haveReq & (gainHold_q == 2'h0);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            divCnt_q <= '0;
        end else if (!enable || flushNow || divCnt_q == prescaler) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + PRESC_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Pending starts, start bits and gain hold-off
    // ------------------------------------------------------------------
    wire logic [NUM_CH-1:0] issueMask = issueOk ? NUM_CH'(1) << pickChan : '0;
    wire logic [1:0] gainHold_d = issueOk ? (pickGain ? 2'h1 : 2'h0) :
                                  ((tick | flushTick) && gainHold_q != 2'h0) ?
                                  gainHold_q - 2'h1 : gainHold_q;

    // Free-running: once the last channel of a sweep issues, the whole group
    // re-arms, so with no gain-stage channel in the sweep the pipeline takes a new sample on every tick
    wire logic [NUM_CH-1:0] sweepLeft = reqAll & ~issueMask & sweepMask;
    wire logic [NUM_CH-1:0] rerun = (continuousSweepEnable && |(issueMask & sweepMask)
                                     && sweepLeft == '0) ? sweepMask : '0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_q <= '0;
            startBits_q <= '0;
            gainHold_q <= 2'h0;
        end else begin
            // Pending starts survive a flush and re-enter afterwards
            pending_q <= (pending_q & ~issueMask) | evStart | rerun;
            startBits_q <= (startBits_q & ~issueMask) | channelStartWrite;
            gainHold_q <= flushTick ? (issueOk ? gainHold_d : 2'h0) : gainHold_d;
        end
    end

    // ------------------------------------------------------------------
    // Pipeline slots
    // ------------------------------------------------------------------
    logic [$clog2(SLOTS)-1:0] freeIdx;
    always_comb begin
        freeIdx = '0;
        for (int s = SLOTS - 1; s >= 0; s--) begin
            if (!slot_q[s].busy) begin
                freeIdx = $clog2(SLOTS)'(s);
            end
        end
    end

    // Conversions in flight, for the occupancy check
    logic [$clog2(SLOTS):0] busyCount;
    always_comb begin
        busyCount = '0;
        for (int s = 0; s < SLOTS; s++) begin
            busyCount = busyCount + ($clog2(SLOTS) + 1)'(slot_q[s].busy);
        end
    end

    logic [NUM_CH-1:0] doneMask;
    logic [NUM_CH-1:0][RES_W-1:0] doneRaw;
    always_comb begin
        doneMask = '0;
        doneRaw = '0;
        for (int s = 0; s < SLOTS; s++) begin
            if (tick && slot_q[s].busy && slot_q[s].left == LAT_BASE) begin
                doneMask[slot_q[s].chan] = 1'b1;
                doneRaw[slot_q[s].chan] = coreResult;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slot_q <= '0;
            lastChan_q <= 2'h0;
        end else begin
            for (int s = 0; s < SLOTS; s++) begin
                if (flushTick) begin
                    slot_q[s] <= '0;
                end else if (tick && slot_q[s].busy) begin
                    slot_q[s].left <= slot_q[s].left - LAT_BASE;
                    if (slot_q[s].left == LAT_BASE) begin
                        slot_q[s].busy <= 1'b0;
                    end
                end
            end
            if (issueOk) begin
                slot_q[freeIdx] <= '{busy: 1'b1, chan: pickChan,
                                     left: latency(resolution, pickGain)};
                lastChan_q <= pickChan;
            end
        end
    end

    // ------------------------------------------------------------------
    // Results, flags, events and DMA
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] hit;
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            case (chanCfg[c].cond)
                COND_ABOVE: hit[c] = doneMask[c] && doneRaw[c] > threshold;
                COND_BELOW: hit[c] = doneMask[c] && doneRaw[c] < threshold;
                default: hit[c] = doneMask[c];
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chanResult <= '0;
            chanFlag <= '0;
            chanEvent <= '0;
            dmaRequest <= '0;
            calibValue <= '0;
            sampleStrobe <= 1'b0;
            gainSampleStrobe <= 1'b0;
            sampleChannel <= 2'h0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (doneMask[c]) begin
                    chanResult[c] <= format(doneRaw[c], resolution, signedSelect);
                end
            end
            chanFlag <= (chanFlag & ~flagClear) | hit; // set wins over clear
            chanEvent <= hit;
            dmaRequest <= doneMask;
            if (calibWrite) begin
                calibValue <= calibIn;
            end
            // Gain channels pulse only gainSampleStrobe; sampleStrobe is raised for non-gain channels only
            sampleStrobe <= issueOk & ~pickGain;
            gainSampleStrobe <= issueOk & pickGain;
            sampleChannel <= issueOk ? pickChan : sampleChannel;
        end
    end

    assign channelStartBits = startBits_q;
    assign adcClkEnable = tick | flushTick;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_PRIORITY: assert property (@(posedge clk) disable iff (reset)
        issueOk |-> ((reqAll & ((NUM_CH'(1) << pickChan) - NUM_CH'(1))) == '0))
        else $error("lower channel skipped");
    AST_START_CLEAR: assert property (@(posedge clk) disable iff (reset)
        (issueOk && !channelStartWrite[pickChan]) |=> !startBits_q[$past(pickChan)])
        else $error("start bit not cleared");
    AST_FLUSH: assert property (@(posedge clk) disable iff (reset)
        (flushTick && !issueOk) |=> (slot_q == '0) && divCnt_q == '0)
        else $error("flush left state");
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (reset)
        (hit != '0) |=> ((chanFlag & $past(hit)) == $past(hit)))
        else $error("flag not set");
    AST_DMA: assert property (@(posedge clk) disable iff (reset)
        dmaRequest[0] |-> $past(doneMask[0]))
        else $error("dma without completion");
    AST_ABOVE: assert property (@(posedge clk) disable iff (reset)
        (doneMask[0] && chanCfg[0].cond == COND_ABOVE && doneRaw[0] <= threshold)
        |-> !hit[0]) else $error("compare leak");
    AST_GAIN_GAP: assert property (@(posedge clk) disable iff (reset)
        (issueOk && pickGain && !flushNow) |=> !issueOk)
        else $error("gain gap missing");
    AST_SIGN: assert property (@(posedge clk) disable iff (reset)
        (doneMask[0] && resolution == RES_12R && signedSelect)
        |=> chanResult[0][15:12] == {4{chanResult[0][11]}})
        else $error("sign not extended");
    AST_INFLIGHT: assert property (@(posedge clk) disable iff (reset)
        issueOk |-> !slot_q[freeIdx].busy || flushTick)
        else $error("pipeline overfull");
    AST_OCCUPANCY: assert property (@(posedge clk) disable iff (reset)
        (issueOk && !flushTick) |-> busyCount < SLOTS)
        else $error("no free slot at issue");
    AST_BELOW: assert property (@(posedge clk) disable iff (reset)
        (doneMask[0] && chanCfg[0].cond == COND_BELOW && doneRaw[0] >= threshold)
        |-> !hit[0]) else $error("compare leak below");
    AST_EVENT: assert property (@(posedge clk) disable iff (reset)
        chanEvent[0] |-> $past(doneMask[0]))
        else $error("event without completion");
    AST_DMA_ALL: assert property (@(posedge clk) disable iff (reset)
        dmaRequest == $past(doneMask))
        else $error("dma request mismatch");
    AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (reset)
        !doneMask[0] |=> $stable(chanResult[0]))
        else $error("result changed without completion");
    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (reset)
        (chanFlag[0] && !flagClear[0]) |=> chanFlag[0])
        else $error("flag dropped");
    AST_CALIB: assert property (@(posedge clk) disable iff (reset)
        calibWrite |=> calibValue == $past(calibIn))
        else $error("calibration not stored");

    // ------------------------------------------------------------------
    // Checks on starts and sampling
    // ------------------------------------------------------------------
    AST_NO_RUN: assert property (@(posedge clk) disable iff (reset)
        !enable |-> !adcClkEnable)
        else $error("tick while disabled");
    AST_START_SET: assert property (@(posedge clk) disable iff (reset)
        channelStartWrite[0] |=> startBits_q[0])
        else $error("start bit not set");
    AST_SAMPLE: assert property (@(posedge clk) disable iff (reset)
        (issueOk && !pickGain) |=> sampleStrobe && sampleChannel == $past(pickChan))
        else $error("sample strobe missing");
    AST_GAIN_SAMPLE: assert property (@(posedge clk) disable iff (reset)
        (issueOk && pickGain) |=> gainSampleStrobe && !sampleStrobe)
        else $error("gain sample strobe missing");
    AST_REARM: assert property (@(posedge clk) disable iff (reset)
        (|rerun) |=> (pending_q & $past(sweepMask)) == $past(sweepMask))
        else $error("sweep not re-armed");

    COV_SINGLE: cover property (@(posedge clk) disable iff (reset) issueOk ##[1:20] doneMask[0]);
    COV_TWO: cover property (@(posedge clk) disable iff (reset) channelStartWrite == 4'h3);
    COV_FLUSH: cover property (@(posedge clk) disable iff (reset) flushTick && |pending_q);
    COV_FREE: cover property (@(posedge clk) disable iff (reset) |rerun);
    COV_GAIN: cover property (@(posedge clk) disable iff (reset) gainSampleStrobe);

endmodule : pipelined_adc_sequencer

/* File: analog_core_model.sv */
// Behavioural analog core that faces the sequencer.
// Assumes the bench sets the code only while the pipeline is idle.
`timescale 1ns/10ps

module analog_core_model
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sampleStrobe,
    input wire logic [1:0] sampleChannel,
    input wire logic [RES_W-1:0] code,
    output logic [RES_W-1:0] coreResult,
    output logic [NUM_CH-1:0] sampledSeen
);
    // ------------------------------------------------------------------
    // Returns the held code; notes which channels were really sampled
    // ------------------------------------------------------------------
    assign coreResult = code;
    initial sampledSeen = '0;
    always @(posedge clk) begin
        if (sampleStrobe === 1'b1) begin
            sampledSeen[sampleChannel] <= 1'b1;
        end
    end
endmodule : analog_core_model

/* File: pipelined_adc_sequencer_test.sv */
// Self-checking bench for the pipelined converter sequencer.
// Assumes the analog core model and the package are compiled first.
`timescale 1ns/10ps

module pipelined_adc_sequencer_test;
    import adc_seq_pkg::*;
    typedef struct {int ch; logic [WORD_W-1:0] val; logic ev; int at;} note_t;
    logic clk, reset, enable, eventFlushEnable, flushWrite, signedSelect;
    logic continuousSweepEnable, calibWrite, adcClkEnable, sampleStrobe, gainSampleStrobe;
    logic [NUM_CH-1:0] channelStartWrite, eventIn, flagClear, channelStartBits;
    logic [NUM_CH-1:0] chanFlag, chanEvent, dmaRequest, sampledSeen;
    logic [PRESC_W-1:0] prescaler;
    logic [1:0] resolution, sweepSelect, sampleChannel;
    logic [RES_W-1:0] threshold, coreResult, code;
    chan_cfg_t [NUM_CH-1:0] chanCfg;
    logic [WORD_W-1:0] calibIn, calibValue, v;
    logic [NUM_CH-1:0][WORD_W-1:0] chanResult;
    int errors = 0, checks_done = 0, cyc = 0, base, mode = 0, lastCh = 1, freeCount = 0;
    int seed, ticks, t;
    note_t expQ[$];
    note_t n;

    pipelined_adc_sequencer dut (.clk(clk), .reset(reset), .enable(enable),
        .channelStartWrite(channelStartWrite), .eventIn(eventIn),
        .eventFlushEnable(eventFlushEnable), .flushWrite(flushWrite), .prescaler(prescaler),
        .resolution(resolution), .signedSelect(signedSelect),
        .continuousSweepEnable(continuousSweepEnable), .sweepSelect(sweepSelect),
        .threshold(threshold), .chanCfg(chanCfg), .calibIn(calibIn), .calibWrite(calibWrite),
        .coreResult(coreResult), .flagClear(flagClear), .channelStartBits(channelStartBits),
        .adcClkEnable(adcClkEnable), .sampleStrobe(sampleStrobe),
        .gainSampleStrobe(gainSampleStrobe), .sampleChannel(sampleChannel),
        .calibValue(calibValue), .chanResult(chanResult), .chanFlag(chanFlag),
        .chanEvent(chanEvent), .dmaRequest(dmaRequest));
    analog_core_model core (.clk(clk), .sampleStrobe(sampleStrobe),
        .sampleChannel(sampleChannel), .code(code), .coreResult(coreResult),
        .sampledSeen(sampledSeen));

    // ------------------------------------------------------------------
    // Clock, cycle count and helpers
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) cyc++;

    task automatic check(input string name, input logic [WORD_W-1:0] seen,
                         input logic [WORD_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [WORD_W-1:0] fmt(input logic [RES_W-1:0] c,
                                              input logic [1:0] r, input logic s);
        if (r == RES_8R) return {{8{s & c[11]}}, c[11:4]};
        if (r == RES_12L) return {c, 4'h0};
        return {{4{s & c[11]}}, c};
    endfunction : fmt

    // Start write is one clock ahead of the tick that serves it
    task automatic startConv(input logic [NUM_CH-1:0] mask, input logic [RES_W-1:0] c);
        @(posedge clk);
        base = cyc;
        code <= c;
        channelStartWrite <= mask;
        @(posedge clk);
        channelStartWrite <= '0;
    endtask : startConv

    task automatic pulseFlush(input int gap);
        repeat (gap) @(posedge clk);
        flushWrite <= 1'b1;
        @(posedge clk);
        flushWrite <= 1'b0;
    endtask : pulseFlush

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // Result watcher: takes the oldest note at each completion in mode 0
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (dmaRequest[i] === 1'b1 && mode != 0) begin
                if (mode == 1) check("sweep order", 16'(i), 16'(lastCh ^ 1));
                lastCh = i;
                freeCount++;
            end else if (dmaRequest[i] === 1'b1 && mode == 0) begin
                if (expQ.size() == 0) begin
                    check("unexpected completion", 16'(i), 16'hFFFF);
                end else begin
                    n = expQ.pop_front();
                    check("channel", 16'(i), 16'(n.ch));
                    check("result", chanResult[i], n.val);
                    check("event", 16'(chanEvent[i]), 16'(n.ev));
                    if (n.ev) check("flag", 16'(chanFlag[i]), 16'h0001);
                    if (n.at >= 0) check("latency", 16'(cyc), 16'(n.at));
                end
            end
        end
    end

    initial begin
        #(30000 * 5);
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        seed = 32'hBC3FD3FA;
        {enable, eventFlushEnable, flushWrite, signedSelect, continuousSweepEnable} = '0;
        {calibWrite, channelStartWrite, eventIn, flagClear, prescaler} = '0;
        {resolution, sweepSelect, threshold, chanCfg, calibIn, code} = '0;
        reset = 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        enable <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            @(posedge clk) prescaler <= p[2:0];
            repeat (3) @(posedge clk);
            ticks = 0;
            repeat (8 * (p + 1)) begin
                @(posedge clk);
                ticks += int'(adcClkEnable === 1'b1);
            end
            check("tick count", 16'(ticks), 16'h0008);
        end
        @(posedge clk) prescaler <= '0;
        calibIn <= 16'($random(seed));
        calibWrite <= 1'b1;
        @(posedge clk) calibWrite <= 1'b0;
        @(posedge clk) check("calibration", calibValue, calibIn);
        $display("test prescaler and calibration done");
        for (int k = 0; k < 8; k++) begin
            @(posedge clk) resolution <= k[1:0];
            signedSelect <= k[2];
            startConv(4'h4, 12'($random(seed)));
            t = (k[1:0] == RES_8R) ? 5 : 7;
            expQ.push_back('{2, fmt(code, k[1:0], k[2]), 1'b1, base + 3 + t});
            repeat (12) @(posedge clk);
            check("start bits", 16'(channelStartBits), 16'h0000);
        end
        @(posedge clk) {resolution, signedSelect} <= '0;
        $display("test resolution done");
        for (int g = 0; g < 4; g++) begin
            @(posedge clk) chanCfg[0].gainUse <= g[0];
            chanCfg[1].gainUse <= g[1];
            startConv(4'h3, 12'($random(seed)));
            expQ.push_back('{0, fmt(code, 2'h0, 1'b0), 1'b1, base + 10 + g[0]});
            expQ.push_back('{1, fmt(code, 2'h0, 1'b0), 1'b1, base + 11 + g[0] + g[1]});
            repeat (16) @(posedge clk);
        end
        @(posedge clk) chanCfg <= '0;
        check("sampled channels", 16'(sampledSeen), 16'h0007);
        $display("test pair and gain done");
        threshold <= (12'($random(seed)) & 12'h7FF) | 12'h010;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk) chanCfg[3].cond <= (k < 3) ? COND_ABOVE : COND_BELOW;
            startConv(4'h8, threshold + 12'(k % 3) - 12'h001);
            v = 16'(k < 3 ? code > threshold : code < threshold);
            expQ.push_back('{3, fmt(code, 2'h0, 1'b0), v[0], base + 10});
            repeat (12) @(posedge clk);
            flagClear <= 4'hF;
            @(posedge clk) flagClear <= '0;
        end
        $display("test compare done");
        startConv(4'h1, 12'($random(seed)));
        pulseFlush(2);
        repeat (15) @(posedge clk);
        eventFlushEnable <= 1'b1;
        startConv(4'h2, 12'($random(seed)));
        repeat (2) @(posedge clk);
        eventIn <= 4'h1;
        expQ.push_back('{0, fmt(code, 2'h0, 1'b0), 1'b1, -1});
        @(posedge clk) eventIn <= '0;
        repeat (15) @(posedge clk);
        eventFlushEnable <= 1'b0;
        $display("test flush done");
        sweepSelect <= 2'h1;
        continuousSweepEnable <= 1'b1;
        mode <= 1;
        eventIn <= 4'h1;
        @(posedge clk) eventIn <= '0;
        repeat (12) @(posedge clk);
        freeCount = 0;
        repeat (40) @(posedge clk);
        check("free results", 16'(freeCount >= 30), 16'h0001);
        mode <= 2;
        pulseFlush(1);
        freeCount = 0;
        repeat (30) @(posedge clk);
        check("resume after flush", 16'(freeCount > 0), 16'h0001);
        continuousSweepEnable <= 1'b0;
        repeat (30) @(posedge clk);
        mode <= 0;
        $display("test free running done");
        check("notes left", 16'(expQ.size()), 16'h0000);
        end_of_test();
    end
endmodule : pipelined_adc_sequencer_test
